// [core/stfs_pkg.sv]
// Constants and carrier types for the supply and thermal fault supervisor
package stfs_pkg;
  // Short-circuit filter time, typical figure, in microseconds
  localparam int SC_FILTER_US = 4000;
  localparam int CLK_MHZ = 25;
  localparam int SC_FILTER_CYC = SC_FILTER_US * CLK_MHZ;
  // Chip cool-down time in fail-safe, microseconds (typical)
  localparam int COOL_DOWN_US = 100000;
  localparam int COOL_DOWN_CYC = COOL_DOWN_US * CLK_MHZ;
  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [1:0] FAULT_OVERTEMP = 2'h1;
  localparam int NUM_HS = 4;
  localparam int NUM_LIN = 2;

  typedef enum logic [1:0] {
    STFS_NORMAL = 2'b00,
    STFS_FAILSAFE = 2'b01,
    STFS_RESTART = 2'b10
  } stfs_mode_e;

  // Raw comparator conditions from the analog side
  typedef struct packed {
    logic mainBelowReset;
    logic batteryLow;
    logic auxCurrentLimit;
    logic auxUnder;
    logic secondaryUnder;
    logic canSupplyUnder;
    logic secondaryHot;
    logic auxHot;
    logic canHot;
    logic [NUM_LIN-1:0] linHot;
    logic [NUM_HS-1:0] hsHot;
    logic mainPrewarn;
    logic chipHot;
  } stfs_cond_s;

  // Sticky flags, also used as the clear-request layout
  typedef struct packed {
    logic mainShort;
    logic flag_a;
    logic auxOvercurrent;
    logic auxUnder;
    logic secondaryUnder;
    logic canSupplyUnder;
    logic blockOvertemp;
    logic secondaryOvertemp;
    logic auxOvertemp;
    logic [NUM_HS-1:0] highside;
    logic prewarn;
    logic chipOvertemp;
  } stfs_flags_s;
endpackage : stfs_pkg

// [core/stfs_sticky.sv]
// Sticky flag with set-over-clear and clear only when the cause is gone
module stfs_sticky (
  input wire logic clk,
  input wire logic rstn,
  input wire logic set,
  input wire logic cause,
  input wire logic clr,
  output logic flag
);
  wire clrOk = clr & ~cause;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clrOk) begin
      flag <= 1'b0;
    end
  end
endmodule : stfs_sticky

// [core/stfs_supervisor.sv]
// Supply short, undervoltage and thermal fault supervision
// Overview of operation
// - Main output not up within filter time after start: short, off, fail, fail-safe
// - After short shutdown, leave fail-safe only on CAN, LIN or wake input
// - Main output below reset threshold longer than filter time: same response
// - Short detection only while battery is above undervoltage
// - Shared load: transistor off on low battery or stop unless keep bits set
// - Shared load: only transistor cut-off diagnostics remain active
// - Stand-alone: overcurrent and undervoltage flags, transistor off on low battery
// - No short flag during main power-up until the filter time expires, no aux UV flag during aux turn-on
// - Secondary and CAN supply undervoltage flags stay until cleared
// - Secondary UV flag suppressed while that supply switches on or off
// - Block overtemp switches that block off and sets block flag
// - Block thermal monitoring only while that block is on, or for aux while load sharing
// - Secondary overtemp: off, on bits cleared, flag set, stays off
// - Stand-alone aux overtemp: off, on bits cleared, flag set
// - Shared aux overtemp: flag, off, automatic restart on recovery
// - CAN overtemp: transmitter off, status 01, auto re-enable
// - LIN overtemp: transmitter off, status 01, auto re-enable
// - Any high-side overtemp: all switches off, controls cleared, flags set
// - Thermal flags only cleared by software after recovery
// - Prewarning flag while main on, cleared only after recovery
// - Chip shutdown: fail-safe for cool-down, then restart, then normal
// - Chip overtemp flag, clear only in normal mode after recovery
module stfs_supervisor #(
  parameter int SC_CYC = stfs_pkg::SC_FILTER_CYC,
  parameter int COOL_CYC = stfs_pkg::COOL_DOWN_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire stfs_pkg::stfs_cond_s cond,
  input wire logic mainStartup,
  input wire logic secondarySwitching,
  input wire logic auxTurningOn,
  input wire logic loadShare,
  input wire logic stopMode,
  input wire logic aux_keep_on_low_battery,
  input wire logic shared_load_stop_keep_on,
  input wire logic wakeCan,
  input wire logic wakeLin,
  input wire logic [2:0] wake_inputs,
  input wire logic secondaryOnSet,
  input wire logic auxOnSet,
  input wire logic canOn,
  input wire logic [stfs_pkg::NUM_LIN-1:0] linOn,
  input wire logic [stfs_pkg::NUM_HS-1:0] highsideSet,
  input wire stfs_pkg::stfs_flags_s clearReq,
  output stfs_pkg::stfs_flags_s flags,
  output logic mainRegOn,
  output logic fail_outputs,
  output logic secondary_on_ctrl,
  output logic aux_on_ctrl,
  output logic auxTransistorEn,
  output logic canTxEn,
  output logic [1:0] canFaultStatus,
  output logic [stfs_pkg::NUM_LIN-1:0] linTxEn,
  output logic [1:0] lin_fault_status [stfs_pkg::NUM_LIN],
  output logic [stfs_pkg::NUM_HS-1:0] highside_switches,
  output stfs_pkg::stfs_mode_e mode
);
  import stfs_pkg::*;

  localparam int SCW = $clog2(SC_CYC + 1);
  localparam int CDW = $clog2(COOL_CYC + 1);

  logic [SCW-1:0] scCount;
  logic [CDW-1:0] coolCount;
  logic shortLatched;
  logic auxLock;
  logic secLock;
  logic hsLock;
  stfs_mode_e next_mode;
  stfs_flags_s setv;
  stfs_flags_s cause;
  stfs_flags_s clrv;

  // Short filter: counting while the main output is low, battery fine
  wire scWatch = mainRegOn & cond.mainBelowReset & ~cond.batteryLow;
  wire scExpire = scWatch && (scCount == SCW'(SC_CYC - 1));
  // Startup must still be watched by the filter; only the flag waits for timeout
  wire shortEvt = scExpire;
  wire anyWake = wakeCan | wakeLin | (|wake_inputs);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scCount <= '0;
    end else if (!scWatch || scExpire) begin
      scCount <= '0;
    end else begin
      scCount <= scCount + SCW'(1);
    end
  end

  // Main regulator off after a short until a bus or pin wake
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shortLatched <= 1'b0;
    end else if (shortEvt) begin
      shortLatched <= 1'b1;
    end else if (anyWake) begin
      shortLatched <= 1'b0;
    end
  end
  assign mainRegOn = ~shortLatched;

  // Thermal monitors gated by block on state, for aux also by load sharing
  wire secHotEvt = secondary_on_ctrl & cond.secondaryHot;
  wire auxHotEvt = (aux_on_ctrl | loadShare) & cond.auxHot;
  wire canHotEvt = canOn & cond.canHot;
  wire [NUM_LIN-1:0] linHotEvt = linOn & cond.linHot;
  wire hsHotAny = |(highside_switches & cond.hsHot);
  wire pwEvt = mainRegOn & cond.mainPrewarn;
  wire chipEvt = mainRegOn & cond.chipHot & (mode == STFS_NORMAL);
  wire blockEvt = secHotEvt | auxHotEvt | canHotEvt | (|linHotEvt) | hsHotAny;

  // Flag sets
  always_comb begin
    setv = '0;
    setv.mainShort = shortEvt;
    setv.flag_a = shortEvt;
    setv.auxOvercurrent = ~loadShare & cond.auxCurrentLimit;
    setv.auxUnder = ~loadShare & aux_on_ctrl & ~auxTurningOn & cond.auxUnder;
    setv.secondaryUnder = cond.secondaryUnder & ~secondarySwitching;
    setv.canSupplyUnder = cond.canSupplyUnder;
    setv.blockOvertemp = blockEvt;
    setv.secondaryOvertemp = secHotEvt;
    setv.auxOvertemp = auxHotEvt;
    setv.highside = hsHotAny ? {NUM_HS{1'b1}} : '0;
    setv.prewarn = pwEvt;
    setv.chipOvertemp = chipEvt;
  end

  // Present causes that block clearing
  always_comb begin
    cause = '0;
    cause.mainShort = shortLatched;
    cause.auxOvercurrent = cond.auxCurrentLimit;
    cause.auxUnder = cond.auxUnder;
    cause.secondaryUnder = cond.secondaryUnder;
    cause.canSupplyUnder = cond.canSupplyUnder;
    cause.blockOvertemp = cond.secondaryHot | cond.auxHot | cond.canHot
      | (|cond.linHot) | (|cond.hsHot);
    cause.secondaryOvertemp = cond.secondaryHot;
    cause.auxOvertemp = cond.auxHot;
    cause.highside = cond.hsHot;
    cause.prewarn = cond.mainPrewarn;
    cause.chipOvertemp = cond.chipHot;
  end

  // Chip flag only clearable in normal mode
  always_comb begin
    clrv = clearReq;
    clrv.chipOvertemp = clearReq.chipOvertemp & (mode == STFS_NORMAL);
  end

  // One sticky cell per flag bit
  for (genvar i = 0; i < $bits(stfs_flags_s); i++) begin : gFlag
    stfs_sticky uFlag (
      .clk(clk),
      .rstn(rstn),
      .set(setv[i]),
      .cause(cause[i]),
      .clr(clrv[i]),
      .flag(flags[i])
    );
  end

  // Secondary on control, held off after overtemp until the request is rewritten
  wire secAllowed = secondaryOnSet & ~secLock;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      secondary_on_ctrl <= 1'b0;
      secLock <= 1'b0;
    end else if (secHotEvt) begin
      secondary_on_ctrl <= 1'b0;
      secLock <= 1'b1;
    end else begin
      secondary_on_ctrl <= secAllowed;
      secLock <= secLock & secondaryOnSet;
    end
  end

  // Stand-alone aux control cleared on overtemp and held off until the request drops
  wire auxCut = auxHotEvt & ~loadShare;
  wire auxAllowed = auxOnSet & ~auxLock;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aux_on_ctrl <= 1'b0;
      auxLock <= 1'b0;
    end else if (auxCut) begin
      aux_on_ctrl <= 1'b0;
      auxLock <= 1'b1;
    end else begin
      aux_on_ctrl <= auxAllowed;
      auxLock <= auxLock & auxOnSet;
    end
  end

  // Transistor gating; shared mode restarts when temperature recovers
  wire lowBattCut = cond.batteryLow & ~aux_keep_on_low_battery;
  wire stopCut = loadShare & stopMode & ~shared_load_stop_keep_on;
  wire hotCut = loadShare & cond.auxHot;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      auxTransistorEn <= 1'b0;
    end else begin
      auxTransistorEn <= aux_on_ctrl & ~lowBattCut & ~stopCut & ~hotCut;
    end
  end

  // Transceiver transmitters follow temperature automatically
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      canTxEn <= 1'b0;
      canFaultStatus <= FAULT_NONE;
    end else begin
      canTxEn <= canOn & ~cond.canHot;
      canFaultStatus <= canHotEvt ? FAULT_OVERTEMP : FAULT_NONE;
    end
  end

  for (genvar l = 0; l < NUM_LIN; l++) begin : gLin
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        linTxEn[l] <= 1'b0;
        lin_fault_status[l] <= FAULT_NONE;
      end else begin
        linTxEn[l] <= linOn[l] & ~cond.linHot[l];
        lin_fault_status[l] <= linHotEvt[l] ? FAULT_OVERTEMP : FAULT_NONE;
      end
    end
    lin_ot_a: assert property (@(posedge clk) disable iff (!rstn)
      linHotEvt[l] |=> !linTxEn[l] && lin_fault_status[l] == FAULT_OVERTEMP)
      else $error("lin overtemp response");
  end

  // All high-side switches drop together and wait for all requests to drop
  wire [NUM_HS-1:0] hsAllowed = hsLock ? '0 : highsideSet;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      highside_switches <= '0;
      hsLock <= 1'b0;
    end else if (hsHotAny) begin
      highside_switches <= '0;
      hsLock <= 1'b1;
    end else begin
      highside_switches <= hsAllowed;
      hsLock <= hsLock & (|highsideSet);
    end
  end

  // Mode sequencing for short and chip shutdown
  wire coolDone = (coolCount == CDW'(COOL_CYC - 1));
  always_comb begin
    case (mode)
      STFS_NORMAL: next_mode = (shortEvt | chipEvt) ? STFS_FAILSAFE : STFS_NORMAL;
      STFS_FAILSAFE: begin
        if (shortEvt) begin
          next_mode = STFS_FAILSAFE;
        end else if (shortLatched) begin
          next_mode = anyWake ? STFS_RESTART : STFS_FAILSAFE;
        end else begin
          next_mode = coolDone ? STFS_RESTART : STFS_FAILSAFE;
        end
      end
      STFS_RESTART: next_mode = shortEvt ? STFS_FAILSAFE : STFS_NORMAL;
      default: next_mode = STFS_NORMAL;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode <= STFS_NORMAL;
      coolCount <= '0;
    end else begin
      mode <= next_mode;
      coolCount <= (mode == STFS_FAILSAFE && !coolDone) ? coolCount + CDW'(1) : '0;
    end
  end

  // Fail outputs while in fail-safe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fail_outputs <= 1'b0;
    end else begin
      fail_outputs <= (next_mode == STFS_FAILSAFE);
    end
  end

  sequence shortResp;
    !mainRegOn && flags.mainShort && mode == STFS_FAILSAFE && fail_outputs;
  endsequence
  short_off_a: assert property (@(posedge clk) disable iff (!rstn)
    shortEvt |=> shortResp)
    else $error("short did not shut down");
  short_stays_a: assert property (@(posedge clk) disable iff (!rstn)
    shortLatched && !anyWake |=> shortLatched)
    else $error("short released without wake");
  batt_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    cond.batteryLow |-> !shortEvt)
    else $error("short on low battery");
  stop_cut_a: assert property (@(posedge clk) disable iff (!rstn)
    stopCut |=> !auxTransistorEn)
    else $error("transistor on in stop mode");
  share_diag_a: assert property (@(posedge clk) disable iff (!rstn)
    loadShare && !flags.auxOvercurrent |=> !flags.auxOvercurrent)
    else $error("aux diagnostics active in load sharing");
  aux_uv_a: assert property (@(posedge clk) disable iff (!rstn)
    auxTurningOn && !flags.auxUnder |=> !flags.auxUnder)
    else $error("aux uv during turn on");
  start_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
    mainStartup && !scExpire && !flags.mainShort |=> !flags.mainShort)
    else $error("short flag during power up");
  can_uv_a: assert property (@(posedge clk) disable iff (!rstn)
    flags.canSupplyUnder && !clearReq.canSupplyUnder |=> flags.canSupplyUnder)
    else $error("can supply uv flag lost");
  sec_ot_a: assert property (@(posedge clk) disable iff (!rstn)
    secHotEvt |=> !secondary_on_ctrl && flags.secondaryOvertemp && flags.blockOvertemp)
    else $error("secondary overtemp response");
  sec_lock_a: assert property (@(posedge clk) disable iff (!rstn)
    secLock && secondaryOnSet |=> !secondary_on_ctrl)
    else $error("secondary back on without rewrite");
  aux_lock_a: assert property (@(posedge clk) disable iff (!rstn)
    auxHotEvt && !loadShare |=> !aux_on_ctrl && flags.auxOvertemp)
    else $error("aux overtemp response");
  aux_share_a: assert property (@(posedge clk) disable iff (!rstn)
    loadShare && cond.auxHot |=> !auxTransistorEn && flags.auxOvertemp)
    else $error("shared aux overtemp response");
  can_ot_a: assert property (@(posedge clk) disable iff (!rstn)
    canHotEvt |=> !canTxEn && canFaultStatus == FAULT_OVERTEMP)
    else $error("can overtemp response");
  hs_ot_a: assert property (@(posedge clk) disable iff (!rstn)
    hsHotAny |=> highside_switches == '0 && (&flags.highside))
    else $error("highside overtemp response");
  hs_lock_a: assert property (@(posedge clk) disable iff (!rstn)
    hsLock |=> highside_switches == '0)
    else $error("highside back on without rewrite");
  prewarn_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    !mainRegOn && !flags.prewarn |=> !flags.prewarn)
    else $error("prewarning while main off");
  chip_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    flags.chipOvertemp && mode != STFS_NORMAL |=> flags.chipOvertemp)
    else $error("chip flag cleared outside normal");
  keep_hot_a: assert property (@(posedge clk) disable iff (!rstn)
    flags.secondaryOvertemp && cond.secondaryHot |=> flags.secondaryOvertemp)
    else $error("flag cleared during overtemp");
  sequence coolSeq;
    mode == STFS_FAILSAFE && !shortLatched && !shortEvt && coolDone;
  endsequence
  chip_seq_a: assert property (@(posedge clk) disable iff (!rstn)
    coolSeq |=> mode == STFS_RESTART ##1 mode == STFS_NORMAL)
    else $error("cool down sequence");
  sec_uv_a: assert property (@(posedge clk) disable iff (!rstn)
    secondarySwitching && !flags.secondaryUnder |=> !flags.secondaryUnder)
    else $error("secondary uv while switching");
endmodule : stfs_supervisor

// [sim/stfs_host_model.sv]
// Host side model that clears sticky fault flags
module stfs_host_model (
  input wire logic clk,
  output stfs_pkg::stfs_flags_s clearReq
);
  timeunit 1ns;
  timeprecision 1ps;
  import stfs_pkg::*;
  initial begin
    clearReq = '0;
  end
  // One-cycle clear; the bench decides whether the cause is already gone
  task automatic clear(input stfs_flags_s mask);
    @(posedge clk);
    #1 clearReq = mask;
    @(posedge clk);
    #1 clearReq = '0;
  endtask : clear
endmodule : stfs_host_model

// [sim/tb_stfs_supervisor.sv]
// Self-checking bench for the supply and thermal fault supervisor
module tb_stfs_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  import stfs_pkg::*;
  localparam int SC = 20;
  localparam int COOL = 30;
  localparam int LIMIT = 2000;
  logic clk, rstn, mainStartup, secondarySwitching, auxTurningOn, loadShare, stopMode;
  logic aux_keep_on_low_battery, shared_load_stop_keep_on, wakeCan, wakeLin;
  logic secondaryOnSet, auxOnSet, canOn, mainRegOn, fail_outputs, secondary_on_ctrl;
  logic aux_on_ctrl, auxTransistorEn, canTxEn, probe;
  logic [2:0] wake_inputs;
  logic [1:0] canFaultStatus;
  logic [NUM_LIN-1:0] linOn, linTxEn;
  logic [1:0] lin_fault_status [NUM_LIN];
  logic [NUM_HS-1:0] highsideSet, highside_switches, hsv;
  stfs_cond_s cond;
  stfs_flags_s clearReq, flags, ef;
  stfs_mode_e mode;
  int fail_count = 0, checks_done = 0, cycles = 0;
  int selQ[$];
  logic [31:0] expQ[$];

  stfs_supervisor #(.SC_CYC(SC), .COOL_CYC(COOL)) stfs_supervisor_i (
    .clk, .rstn, .cond, .mainStartup, .secondarySwitching, .auxTurningOn, .loadShare,
    .stopMode, .aux_keep_on_low_battery, .shared_load_stop_keep_on, .wakeCan, .wakeLin,
    .wake_inputs, .secondaryOnSet, .auxOnSet, .canOn, .linOn, .highsideSet, .clearReq,
    .flags, .mainRegOn, .fail_outputs, .secondary_on_ctrl, .aux_on_ctrl, .auxTransistorEn,
    .canTxEn, .canFaultStatus, .linTxEn, .lin_fault_status, .highside_switches, .mode
  );
  stfs_host_model stfs_host_model_i (.clk, .clearReq);

  always #20 clk = ~clk;

  function automatic logic [31:0] pick(input int s);
    case (s)
      0: return 32'(flags);
      1: return 32'(mode);
      2: return 32'(mainRegOn);
      3: return 32'(fail_outputs);
      4: return 32'(canTxEn);
      5: return 32'(canFaultStatus);
      6: return 32'(linTxEn);
      7: return 32'({lin_fault_status[1], lin_fault_status[0]});
      8: return 32'(highside_switches);
      9: return 32'(secondary_on_ctrl);
      11: return 32'(aux_on_ctrl);
      default: return 32'(auxTransistorEn);
    endcase
  endfunction : pick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Outputs are read at the edge, before that edge's updates land
  always @(posedge clk) begin
    if (probe) begin
      check(pick(selQ.pop_front()), expQ.pop_front());
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic cyc(input int n);
    probe = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : cyc

  // Probe stays high across back-to-back notes
  task automatic note(input int s, input logic [31:0] v);
    selQ.push_back(s);
    expQ.push_back(v);
    probe = 1'b1;
    @(posedge clk);
    #1;
  endtask : note

  task automatic clr(input stfs_flags_s m);
    cyc(0);
    stfs_host_model_i.clear(m);
    cyc(2);
  endtask : clr

  task automatic wait_mode(input stfs_mode_e m);
    int n;
    n = 0;
    cyc(0);
    while (mode !== m && n < 100) begin
      cyc(1);
      n++;
    end
  endtask : wait_mode

  initial begin
    {cond, linOn, highsideSet, wake_inputs, mainStartup, secondarySwitching, auxTurningOn,
     loadShare, stopMode, aux_keep_on_low_battery, shared_load_stop_keep_on, wakeCan, wakeLin,
     secondaryOnSet, auxOnSet, canOn, probe, rstn, clk} = '0;
    void'($urandom(32'hF94BC05B));
    cyc(4);
    rstn = 1'b1;
    cond.batteryLow = 1'b1;
    cond.mainBelowReset = 1'b1;
    cyc(SC + 5);
    note(0, 0);
    cond.mainBelowReset = 1'b0;
    cyc(2);
    {cond.batteryLow, cond.mainBelowReset} = 2'h1;
    mainStartup = 1'b1;
    cyc(SC - 3);
    note(0, 0);
    cyc(8);
    ef = '0;
    {ef.mainShort, ef.flag_a} = 2'h3;
    note(0, 32'(ef));
    note(1, 32'(STFS_FAILSAFE));
    note(3, 1);
    note(2, 0);
    {cond.mainBelowReset, mainStartup} = 2'h0;
    cyc(5);
    note(1, 32'(STFS_FAILSAFE));
    case ($urandom % 3)
      0: wakeCan = 1'b1;
      1: wakeLin = 1'b1;
      default: wake_inputs = 3'(1 << ($urandom % 3));
    endcase
    cyc(2);
    {wakeCan, wakeLin, wake_inputs} = '0;
    wait_mode(STFS_NORMAL);
    note(1, 32'(STFS_NORMAL));
    note(2, 1);
    clr('1);
    note(0, 0);
    // Undervoltage flags of the secondary and CAN supplies
    {secondarySwitching, cond.secondaryUnder, cond.canSupplyUnder} = 3'h7;
    cyc(3);
    ef = '0;
    ef.canSupplyUnder = 1'b1;
    note(0, 32'(ef));
    secondarySwitching = 1'b0;
    cyc(3);
    ef.secondaryUnder = 1'b1;
    note(0, 32'(ef));
    clr('1);
    note(0, 32'(ef));
    cond = '0;
    cyc(3);
    note(0, 32'(ef));
    clr('1);
    note(0, 0);
    // Block thermal shutdown
    hsv = 4'($urandom_range(15, 1));
    cond.hsHot = hsv;
    cyc(3);
    note(0, 0);
    cond.hsHot = '0;
    {canOn, secondaryOnSet, linOn, highsideSet} = {2'h3, {NUM_LIN{1'b1}}, hsv};
    cyc(3);
    note(4, 1);
    note(8, 32'(hsv));
    note(9, 1);
    {cond.canHot, cond.secondaryHot, cond.linHot} = '1;
    cond.hsHot = hsv & ~(hsv - 4'h1);
    cyc(3);
    ef = '0;
    {ef.blockOvertemp, ef.secondaryOvertemp, ef.highside} = '1;
    note(0, 32'(ef));
    note(4, 0);
    note(5, 32'(FAULT_OVERTEMP));
    note(6, 0);
    note(7, 32'({FAULT_OVERTEMP, FAULT_OVERTEMP}));
    note(8, 0);
    note(9, 0);
    {cond, secondaryOnSet, highsideSet} = '0;
    cyc(3);
    note(4, 1);
    note(6, 32'({NUM_LIN{1'b1}}));
    note(0, 32'(ef));
    clr('1);
    note(0, 0);
    // Auxiliary regulator diagnostics, shared then stand-alone
    aux_keep_on_low_battery = 1'($urandom);
    {loadShare, auxOnSet, shared_load_stop_keep_on} = 3'h7;
    {cond.auxCurrentLimit, cond.batteryLow} = 2'h3;
    cyc(3);
    note(10, 32'(aux_keep_on_low_battery));
    note(0, 0);
    {cond.batteryLow, stopMode, shared_load_stop_keep_on} = 3'h2;
    cyc(3);
    note(10, 0);
    {loadShare, stopMode} = 2'h0;
    cyc(3);
    ef = '0;
    ef.auxOvercurrent = 1'b1;
    note(0, 32'(ef));
    cond = '0;
    clr('1);
    note(0, 0);
    // Aux undervoltage hidden at turn-on, then stand-alone and shared overtemp
    {auxTurningOn, cond.auxUnder} = 2'h3;
    cyc(3);
    note(0, 0);
    auxTurningOn = 1'b0;
    cyc(2);
    ef = '0;
    ef.auxUnder = 1'b1;
    note(0, 32'(ef));
    cond.auxHot = 1'b1;
    cyc(3);
    {ef.blockOvertemp, ef.auxOvertemp} = 2'h3;
    note(0, 32'(ef));
    note(11, 0);
    {cond, auxOnSet} = '0;
    clr('1);
    note(0, 0);
    {loadShare, auxOnSet, cond.auxHot} = 3'h7;
    cyc(3);
    ef = '0;
    {ef.blockOvertemp, ef.auxOvertemp} = 2'h3;
    note(0, 32'(ef));
    note(10, 0);
    cond.auxHot = 1'b0;
    cyc(3);
    note(10, 1);
    note(11, 1);
    {loadShare, auxOnSet} = 2'h0;
    clr('1);
    note(0, 0);
    // Prewarning and chip shutdown
    cond.mainPrewarn = 1'b1;
    cyc(3);
    ef = '0;
    ef.prewarn = 1'b1;
    note(0, 32'(ef));
    clr('1);
    note(0, 32'(ef));
    cond.chipHot = 1'b1;
    cyc(2);
    cond = '0;
    cyc(1);
    ef.chipOvertemp = 1'b1;
    note(1, 32'(STFS_FAILSAFE));
    note(0, 32'(ef));
    clr('1);
    ef.prewarn = 1'b0;
    note(0, 32'(ef));
    wait_mode(STFS_NORMAL);
    note(1, 32'(STFS_NORMAL));
    clr('1);
    note(0, 0);
    wrap_up();
  end
endmodule : tb_stfs_supervisor
